// ===== ovr_pkg.sv
// Constants, field layout, modes and states of the over-voltage fault responder
//
// How it works
// - Response 00 ignores over-voltage; output keeps converting.
// - Response 01 keeps running for the delay, then applies the retry setting.
// - Response 10 disables the output at once, then applies the retry setting.
// - Response 11 holds output off while fault persists, then re-enables.
// - Status clear, clear-faults, reset, off-then-on or bias loss clear a latch.
// - Retry 000 means no restart; output stays off until cleared.
// - Retry 1..6 tries that many restarts, then latches off until cleared.
// - Restart attempt starts are spaced by multiplier times the delay unit.
// - Retry 111 restarts forever until off command, bias loss or other fault.
// - Delay field decodes to two to the field value units, 1 to 128.
// - One decoded delay serves both continue time and restart spacing.
// - Unit length comes from the separate timing register, not this one.
// - Fault is present while measured output exceeds the programmed limit.
package ovr_pkg;

    localparam logic [7:0] OVR_CFG_ADDR = 8'h41;
    localparam logic [7:0] OVR_CFG_RESET = 8'h80;
    localparam logic [7:0] OVR_RD_UNMAPPED = 8'h00;

    localparam int OVR_RESP_LO = 6;
    localparam int OVR_RETRY_LO = 3;
    localparam int OVR_DLY_LO = 0;

    localparam logic [1:0] OVR_RESP_IGNORE = 2'h0;
    localparam logic [1:0] OVR_RESP_CONT = 2'h1;
    localparam logic [1:0] OVR_RESP_DISABLE = 2'h2;
    localparam logic [1:0] OVR_RESP_HOLD = 2'h3;

    localparam logic [2:0] OVR_RETRY_NONE = 3'h0;
    localparam logic [2:0] OVR_RETRY_FOREVER = 3'h7;

    localparam logic [7:0] OVR_ONE_UNIT = 8'h01;

    typedef enum logic [6:0] {
        OVR_IDLE = 7'h01,
        OVR_RUN = 7'h02,
        OVR_DELAY = 7'h04,
        OVR_OFF_WAIT = 7'h08,
        OVR_RESTART = 7'h10,
        OVR_LATCH = 7'h20,
        OVR_HOLD = 7'h40
    } ovr_state_e;

    function automatic logic [1:0] ovr_resp_of(input logic [7:0] cfg);
        ovr_resp_of = cfg[OVR_RESP_LO +: 2];
    endfunction : ovr_resp_of

    function automatic logic [2:0] ovr_retry_of(input logic [7:0] cfg);
        ovr_retry_of = cfg[OVR_RETRY_LO +: 3];
    endfunction : ovr_retry_of

    // Power-of-two unit count, 1 up to 128
    function automatic logic [7:0] ovr_units_of(input logic [7:0] cfg);
        ovr_units_of = OVR_ONE_UNIT << cfg[OVR_DLY_LO +: 3];
    endfunction : ovr_units_of

endpackage : ovr_pkg

// ===== ovr_resp.sv
// Output over-voltage fault responder: config register, sequencer and restart control
`timescale 1ns/1ps
module ovr_resp
    import ovr_pkg::*;
#(
    parameter int UNIT_W = 16,
    parameter int VOUT_W = 16
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [7:0] cfg_addr,
    input wire logic [7:0] cfg_wdata,
    output logic [7:0] cfg_rdata,
    input wire logic [VOUT_W-1:0] vout_meas,
    input wire logic [VOUT_W-1:0] vout_ov_limit,
    input wire logic [UNIT_W-1:0] delay_unit_cycles,
    input wire logic on_cmd,
    input wire logic bias_ok,
    input wire logic other_fault_off,
    input wire logic clear_faults,
    input wire logic status_bit_clear,
    output logic output_en,
    output logic ov_status,
    output logic ov_present,
    output logic [2:0] attempts,
    output logic [6:0] resp_state
);

    ////////////////////////////////////////////////////////////////////////////
    // Elaboration checks

    generate
        if (VOUT_W < 1 || VOUT_W > 32) begin : g_chk_vout
            $error("ovr_resp: VOUT_W out of range");
        end
        if (UNIT_W < 2 || UNIT_W > 31) begin : g_chk_unit
            $error("ovr_resp: UNIT_W out of range");
        end
        // Field slices must stay inside the config byte
        if (OVR_RESP_LO + 2 > 8 || OVR_RETRY_LO + 3 > 8 ||
            OVR_DLY_LO + 3 > 8) begin : g_chk_fields
            $error("ovr_resp: config field layout does not fit the byte");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    logic [7:0] cfg_r;
    logic [7:0] cfg_rdata_r;
    logic ov_now_r;
    logic ov_status_r;
    logic output_en_r;
    logic [2:0] attempt_r;
    ovr_state_e state_r;
    ovr_state_e state_nxt;

    logic [1:0] resp;
    logic [2:0] retry;
    logic clr;
    logic stop_all;
    logic can_retry;
    logic tmr_start;
    logic tmr_stop;
    logic att_inc;
    logic att_clr;

    ovr_tmr_if #(.UNIT_W(UNIT_W)) tif ();

    ////////////////////////////////////////////////////////////////////////////
    // Decodes

    // Zero retries sends a disable or delay-expiry shutdown straight to the latch
    function automatic logic no_retry(input logic [2:0] r);
        no_retry = (r == OVR_RETRY_NONE);
    endfunction : no_retry

    function automatic logic retry_left(input logic [2:0] r, input logic [2:0] a);
        retry_left = (r == OVR_RETRY_FOREVER) || (a < r);
    endfunction : retry_left

    // States in which the power stage may run
    function automatic logic stage_on(input ovr_state_e s);
        case (s)
            OVR_RUN, OVR_DELAY, OVR_RESTART: begin
                stage_on = 1'b1;
            end
            default: begin
                stage_on = 1'b0;
            end
        endcase
    endfunction : stage_on

    ////////////////////////////////////////////////////////////////////////////
    // Configuration register

    // Writes land on the next edge; a sequence in flight follows the new mode
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cfg_r <= OVR_CFG_RESET;
        end else if (cfg_wr && cfg_addr == OVR_CFG_ADDR) begin
            cfg_r <= cfg_wdata;
        end
    end

    // Unmapped addresses read as zero
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cfg_rdata_r <= OVR_RD_UNMAPPED;
        end else if (cfg_rd) begin
            cfg_rdata_r <= (cfg_addr == OVR_CFG_ADDR) ? cfg_r : OVR_RD_UNMAPPED;
        end
    end

    assign resp = ovr_resp_of(cfg_r);
    assign retry = ovr_retry_of(cfg_r);

    ////////////////////////////////////////////////////////////////////////////
    // Fault detection

    // Registered compare keeps the comparator out of the sequencer path
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ov_now_r <= 1'b0;
        end else begin
            ov_now_r <= vout_meas > vout_ov_limit;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Clear sources

    // Dropping the on command or bias is the off half of off-then-on
    assign clr = clear_faults || status_bit_clear || !on_cmd || !bias_ok;
    // Another fault stops the sequence and frees a latch as a clear does, but leaves status set
    assign stop_all = clr || other_fault_off;

    // Forever retry ignores the attempt count
    assign can_retry = retry_left(retry, attempt_r);

    ////////////////////////////////////////////////////////////////////////////
    // Delay timer

    assign tif.start = tmr_start;
    assign tif.stop = tmr_stop;
    assign tif.units = ovr_units_of(cfg_r);
    assign tif.unit_cycles = delay_unit_cycles;

    ovr_tmr #(.UNIT_W(UNIT_W)) u_tmr (
        .ref_clk(ref_clk),
        .srst(srst),
        .t(tif.tmr)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_r <= OVR_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_comb begin
        state_nxt = state_r;
        tmr_start = 1'b0;
        tmr_stop = 1'b0;
        att_inc = 1'b0;
        att_clr = 1'b0;
        // Any stop overrides the sequence, so no state can outlive a clear
        if (stop_all) begin
            state_nxt = OVR_IDLE;
            tmr_stop = 1'b1;
            att_clr = 1'b1;
        end else begin
            case (state_r)
                OVR_IDLE: begin
                    state_nxt = OVR_RUN;
                end
                OVR_RUN: begin
                    if (ov_now_r) begin
                        case (resp)
                            OVR_RESP_CONT: begin
                                state_nxt = OVR_DELAY;
                                tmr_start = 1'b1;
                            end
                            OVR_RESP_DISABLE: begin
                                if (no_retry(retry)) begin
                                    state_nxt = OVR_LATCH;
                                end else begin
                                    state_nxt = OVR_OFF_WAIT;
                                    tmr_start = 1'b1;
                                end
                            end
                            OVR_RESP_HOLD: begin
                                state_nxt = OVR_HOLD;
                            end
                            default: begin
                                state_nxt = OVR_RUN;
                            end
                        endcase
                    end
                end
                OVR_DELAY: begin
                    // Output stays on through the delay
                    if (tif.done) begin
                        if (!ov_now_r) begin
                            state_nxt = OVR_RUN;
                        end else if (no_retry(retry)) begin
                            state_nxt = OVR_LATCH;
                        end else begin
                            state_nxt = OVR_OFF_WAIT;
                            tmr_start = 1'b1;
                        end
                    end
                end
                OVR_OFF_WAIT: begin
                    // Timer was started at the shutdown or the previous attempt start, so
                    // attempt starts stay one interval apart
                    if (tif.done) begin
                        state_nxt = OVR_RESTART;
                        tmr_start = 1'b1;
                        att_inc = 1'b1;
                    end
                end
                OVR_RESTART: begin
                    // A fault inside the attempt window fails the attempt
                    if (ov_now_r) begin
                        if (can_retry) begin
                            state_nxt = OVR_OFF_WAIT;
                        end else begin
                            state_nxt = OVR_LATCH;
                            tmr_stop = 1'b1;
                        end
                    end else if (tif.done) begin
                        state_nxt = OVR_RUN;
                        att_clr = 1'b1;
                    end
                end
                OVR_LATCH: begin
                    state_nxt = OVR_LATCH;
                end
                OVR_HOLD: begin
                    if (!ov_now_r) begin
                        state_nxt = OVR_RUN;
                    end
                end
                default: begin
                    state_nxt = OVR_IDLE;
                    tmr_stop = 1'b1;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Attempt counter

    always_ff @(posedge ref_clk) begin
        if (srst || att_clr) begin
            attempt_r <= 3'h0;
        end else if (att_inc && attempt_r != OVR_RETRY_FOREVER) begin
            attempt_r <= attempt_r + 3'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output enable and status

    // Off only in states where the output is disabled or not commanded
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            output_en_r <= 1'b0;
        end else begin
            output_en_r <= stage_on(state_nxt);
        end
    end

    // A new detection wins over a clear in the same cycle
    // Off-then-on leaves status set; only the two clear commands drop it
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ov_status_r <= 1'b0;
        end else if (ov_now_r && resp != OVR_RESP_IGNORE && on_cmd && bias_ok) begin
            ov_status_r <= 1'b1;
        end else if (clear_faults || status_bit_clear) begin
            ov_status_r <= 1'b0;
        end
    end

    assign cfg_rdata = cfg_rdata_r;
    assign output_en = output_en_r;
    assign ov_status = ov_status_r;
    assign ov_present = ov_now_r;
    assign attempts = attempt_r;
    assign resp_state = state_r;

endmodule : ovr_resp

// ===== ovr_resp_checker.sv
// Port assertions for the over-voltage fault responder
`timescale 1ns/1ps
module ovr_resp_checker
    import ovr_pkg::*;
#(
    parameter int VOUT_W = 16
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [7:0] cfg_addr,
    input wire logic [7:0] cfg_wdata,
    input wire logic [7:0] cfg_rdata,
    input wire logic [VOUT_W-1:0] vout_meas,
    input wire logic [VOUT_W-1:0] vout_ov_limit,
    input wire logic on_cmd,
    input wire logic bias_ok,
    input wire logic other_fault_off,
    input wire logic clear_faults,
    input wire logic status_bit_clear,
    input wire logic output_en,
    input wire logic ov_present,
    input wire logic [2:0] attempts,
    input wire logic [6:0] resp_state
);
    logic [7:0] cfg_r;
    logic [7:0] rd_exp;
    logic stop;
    logic over;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    ////////////////////////////////////////////////////////////////////////////
    // Shadow of the config byte, so modes are judged without seeing the body
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cfg_r <= OVR_CFG_RESET;
        end else if (cfg_wr && cfg_addr == OVR_CFG_ADDR) begin
            cfg_r <= cfg_wdata;
        end
    end
    assign rd_exp = (cfg_addr == OVR_CFG_ADDR) ? cfg_r : OVR_RD_UNMAPPED;
    assign stop = clear_faults || status_bit_clear || !on_cmd || !bias_ok || other_fault_off;
    assign over = vout_meas > vout_ov_limit;
    sequence s_hit(logic [1:0] m);
        resp_state == OVR_RUN && ov_present && !stop && cfg_r[OVR_RESP_LO +: 2] == m;
    endsequence
    sequence s_new_try;
        resp_state != OVR_RESTART && attempts != 3'h7 ##1 resp_state == OVR_RESTART;
    endsequence
    ////////////////////////////////////////////////////////////////////////////
    a_ov_compare: assert property (!$past(srst) |-> ov_present == $past(over))
        else $error("ov_present does not follow the limit compare");
    a_ignore_on: assert property (s_hit(OVR_RESP_IGNORE) |=> output_en)
        else $error("output dropped in ignore mode");
    a_cont_runs: assert property (s_hit(OVR_RESP_CONT) |=> output_en)
        else $error("output dropped at once in continue mode");
    a_disable_fast: assert property (s_hit(OVR_RESP_DISABLE) |=> !output_en)
        else $error("output not disabled one edge after fault");
    a_hold_off: assert property (s_hit(OVR_RESP_HOLD) |=> !output_en [*2])
        else $error("output not held off in hold mode");
    a_hold_resume: assert property (resp_state == OVR_HOLD && !ov_present && !stop
        |=> output_en)
        else $error("output not resumed after fault left");
    a_latch_off: assert property (resp_state == OVR_LATCH |-> !output_en)
        else $error("output on while latched");
    a_clear_idle: assert property (stop |=> resp_state == OVR_IDLE && !output_en
        && attempts == 3'h0)
        else $error("clear or stop did not return to idle");
    a_rd_data: assert property (cfg_rd && !cfg_wr |=> cfg_rdata == $past(rd_exp))
        else $error("read data wrong");
    a_restart_inc: assert property (s_new_try |-> output_en
        && attempts == $past(attempts) + 3'h1)
        else $error("restart did not count");
endmodule : ovr_resp_checker
bind ovr_resp ovr_resp_checker #(.VOUT_W(VOUT_W)) u_chk (
    .ref_clk(ref_clk), .srst(srst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .vout_meas(vout_meas),
    .vout_ov_limit(vout_ov_limit), .on_cmd(on_cmd), .bias_ok(bias_ok),
    .other_fault_off(other_fault_off), .clear_faults(clear_faults),
    .status_bit_clear(status_bit_clear), .output_en(output_en), .ov_present(ov_present),
    .attempts(attempts), .resp_state(resp_state)
);

// ===== ovr_resp_tb.sv
// Self-checking bench for the over-voltage fault responder
`timescale 1ns/1ps
module ovr_resp_tb;
    import ovr_pkg::*;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic cfg_wr = 1'b0;
    logic cfg_rd = 1'b0;
    logic [7:0] cfg_addr = 8'h00;
    logic [7:0] cfg_wdata = 8'h00;
    logic [15:0] vout_ov_limit = 16'hc000;
    logic [15:0] delay_unit_cycles = 16'h0002;
    logic on_cmd = 1'b1;
    logic bias_ok = 1'b1;
    logic other_fault_off = 1'b0;
    logic clear_faults = 1'b0;
    logic status_bit_clear = 1'b0;
    logic fault_inj = 1'b0;
    logic [7:0] cfg_rdata;
    logic [15:0] vout_meas;
    logic output_en;
    logic ov_status;
    logic ov_present;
    logic [2:0] attempts;
    logic [6:0] resp_state;
    int mismatches = 0;
    int checked = 0;

    always #10 ref_clk = ~ref_clk;

    ovr_resp dut (.ref_clk(ref_clk), .srst(srst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
        .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
        .vout_meas(vout_meas), .vout_ov_limit(vout_ov_limit),
        .delay_unit_cycles(delay_unit_cycles), .on_cmd(on_cmd), .bias_ok(bias_ok),
        .other_fault_off(other_fault_off), .clear_faults(clear_faults),
        .status_bit_clear(status_bit_clear), .output_en(output_en), .ov_status(ov_status),
        .ov_present(ov_present), .attempts(attempts), .resp_state(resp_state));
    ovr_stage stage (.output_en(output_en), .fault_inj(fault_inj), .vout_meas(vout_meas));
    ////////////////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        cfg_wr = 1'b1;
        cfg_addr = a;
        cfg_wdata = d;
        tick(1);
        cfg_wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        cfg_rd = 1'b1;
        cfg_addr = a;
        tick(1);
        cfg_rd = 1'b0;
        tick(1);
    endtask : rd
    task automatic complete_run();
        $display("checked=%0d mismatches=%0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : complete_run
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        rd(OVR_CFG_ADDR);
        check(16'(cfg_rdata), 16'(OVR_CFG_RESET));
        wr(OVR_CFG_ADDR, 8'h5a);
        rd(OVR_CFG_ADDR);
        check(16'(cfg_rdata), 16'h005a);
        wr(8'h42, 8'hff);
        rd(OVR_CFG_ADDR);
        check(16'(cfg_rdata), 16'h005a);
        rd(8'h42);
        check(16'(cfg_rdata), 16'(OVR_RD_UNMAPPED));
        $display("t_regs done");
    endtask : t_regs
    task automatic t_ignore();
        wr(OVR_CFG_ADDR, 8'h00);
        fault_inj = 1'b1;
        tick(20);
        check(16'({ov_present, output_en, ov_status}), 16'h0006);
        fault_inj = 1'b0;
        tick(3);
        $display("t_ignore done");
    endtask : t_ignore
    task automatic t_latch();
        for (int m = 0; m < 4; m++) begin
            wr(OVR_CFG_ADDR, 8'h80);
            fault_inj = 1'b1;
            tick(3);
            check(16'(output_en), 16'h0000);
            fault_inj = 1'b0;
            tick(10);
            check(16'({output_en, ov_status}), 16'h0001);
            case (m)
                0: clear_faults = 1'b1;
                1: status_bit_clear = 1'b1;
                2: on_cmd = 1'b0;
                default: bias_ok = 1'b0;
            endcase
            tick(1);
            {clear_faults, status_bit_clear, on_cmd, bias_ok} = 4'h3;
            tick(3);
            check(16'({output_en, ov_status}), 16'({1'b1, m >= 2}));
        end
        $display("t_latch done");
    endtask : t_latch
    task automatic t_hold();
        wr(OVR_CFG_ADDR, 8'hc0);
        fault_inj = 1'b1;
        tick(12);
        check(16'({output_en, resp_state}), 16'(OVR_HOLD));
        fault_inj = 1'b0;
        tick(3);
        check(16'(output_en), 16'h0001);
        $display("t_hold done");
    endtask : t_hold
    task automatic t_cont();
        wr(OVR_CFG_ADDR, 8'h42);
        fault_inj = 1'b1;
        tick(7);
        check(16'(output_en), 16'h0001);
        tick(8);
        check(16'({output_en, resp_state}), 16'(OVR_LATCH));
        fault_inj = 1'b0;
        clear_faults = 1'b1;
        tick(1);
        clear_faults = 1'b0;
        tick(3);
        fault_inj = 1'b1;
        tick(3);
        fault_inj = 1'b0;
        tick(20);
        check(16'({output_en, resp_state}), 16'h0080 | 16'(OVR_RUN));
        $display("t_cont done");
    endtask : t_cont
    // Retries against a persistent fault; spacing measured rise to rise
    task automatic t_retry(input logic [2:0] r, input logic [2:0] e, input int span);
        int t0;
        int rises;
        logic en_q;
        t0 = 0;
        rises = 0;
        en_q = 1'b1;
        wr(OVR_CFG_ADDR, {OVR_RESP_DISABLE, r, e});
        fault_inj = 1'b1;
        for (int n = 0; n < span; n++) begin
            tick(1);
            if (output_en && !en_q) begin
                if (rises > 0) check(16'(n - t0), 16'((1 << e) * 2));
                rises++;
                t0 = n;
            end
            en_q = output_en;
        end
        if (r == OVR_RETRY_FOREVER) begin
            check(16'({rises >= 40, attempts}), 16'h000f);
            other_fault_off = 1'b1;
            tick(2);
            check(16'({output_en, attempts}), 16'h0000);
            other_fault_off = 1'b0;
        end else begin
            check(16'(rises), 16'(r));
            check(16'({output_en, attempts, resp_state}), 16'({r, OVR_LATCH}));
            clear_faults = 1'b1;
        end
        fault_inj = 1'b0;
        tick(1);
        clear_faults = 1'b0;
        tick(3);
        check(16'({output_en, attempts}), 16'h0008);
        $display("t_retry done");
    endtask : t_retry
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        tick(10);
        srst = 1'b0;
        tick(3);
        t_regs();
        t_ignore();
        t_latch();
        t_hold();
        t_cont();
        t_retry(3'h0, 3'h0, 50);
        t_retry(3'h1, 3'h0, 50);
        t_retry(3'h2, 3'h1, 100);
        t_retry(3'h6, 3'h3, 400);
        t_retry(3'h3, 3'h7, 1200);
        t_retry(3'h7, 3'h1, 200);
        complete_run();
    end
    // Tests need about 2200 cycles; allow over ten times that
    initial begin
        #600000;
        mismatches++;
        complete_run();
    end
endmodule : ovr_resp_tb

// ===== ovr_stage.sv
// Power stage model giving the measured output voltage
`timescale 1ns/1ps
module ovr_stage #(
    parameter int VOUT_W = 16
) (
    input wire logic output_en,
    input wire logic fault_inj,
    output logic [VOUT_W-1:0] vout_meas
);
    // Over-drive is external and persists with the stage off, so retries fail
    assign vout_meas = fault_inj ? VOUT_W'(16'hf000) :
        (output_en ? VOUT_W'(16'h8000) : VOUT_W'(16'h0000));
endmodule : ovr_stage

// ===== ovr_tmr.sv
// Delay timer counting whole delay units of a programmable cycle length
`timescale 1ns/1ps
module ovr_tmr
    import ovr_pkg::*;
#(
    parameter int UNIT_W = 16
) (
    input wire logic ref_clk,
    input wire logic srst,
    ovr_tmr_if.tmr t
);

    logic busy_r;
    logic [UNIT_W-1:0] cyc_r;
    logic [7:0] left_r;
    logic unit_end;

    generate
        if (UNIT_W < 2 || UNIT_W > 31) begin : g_chk
            $error("ovr_tmr: UNIT_W out of range");
        end
    endgenerate

    // A zero unit length behaves as one cycle so the timer never hangs
    assign unit_end = (t.unit_cycles == '0) ||
                      (cyc_r >= t.unit_cycles - UNIT_W'(1));

    always_ff @(posedge ref_clk) begin
        if (srst || t.stop) begin
            busy_r <= 1'b0;
            cyc_r <= '0;
            left_r <= 8'h00;
        end else if (t.start) begin
            busy_r <= 1'b1;
            cyc_r <= '0;
            left_r <= t.units;
        end else if (busy_r) begin
            if (unit_end) begin
                cyc_r <= '0;
                left_r <= left_r - 8'h01;
                if (left_r == OVR_ONE_UNIT) begin
                    busy_r <= 1'b0;
                end
            end else begin
                cyc_r <= cyc_r + UNIT_W'(1);
            end
        end
    end

    // Done marks the last cycle of the last unit, so the caller moves on the
    // very edge the interval ends and attempt starts stay exactly one delay apart
    assign t.done = busy_r && unit_end && (left_r == OVR_ONE_UNIT);
    assign t.busy = busy_r;

endmodule : ovr_tmr

// ===== ovr_tmr_if.sv
// Carrier between the responder and its delay timer
`timescale 1ns/1ps
interface ovr_tmr_if #(parameter int UNIT_W = 16);
    logic start;
    logic stop;
    logic [7:0] units;
    logic [UNIT_W-1:0] unit_cycles;
    logic done;
    logic busy;

    modport ctl (output start, output stop, output units, output unit_cycles,
                 input done, input busy);
    modport tmr (input start, input stop, input units, input unit_cycles,
                 output done, output busy);
endinterface : ovr_tmr_if
